// [hw/rct_pkg.sv]
// Shared constants and types of the radio code teach-in controller.
// Assumes one 100 MHz clock; the button input is synchronised here, the radio input is synchronous.
`default_nettype none
package rct_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned TICK_S = 1;
	localparam int unsigned DEB_MS = 10;
	localparam int unsigned TICK_CYC = TICK_S * CLK_FREQ_HZ;
	localparam int unsigned DEB_CYC = DEB_MS * (CLK_FREQ_HZ / 1000);
	localparam logic [4:0] HOLD_FLASH_S = 5'h05;
	localparam logic [4:0] HOLD_STEADY_ADD_S = 5'h0a;
	localparam logic [4:0] HOLD_STEADY_S = HOLD_FLASH_S + HOLD_STEADY_ADD_S;
	localparam logic [4:0] HOLD_ALL_S = 5'h19;
	localparam logic [3:0] WAIT_CODE_S = 4'ha;
	// ****************************************
	// Code memory and channels
	// ****************************************
	localparam int unsigned NSLOT = 112;
	localparam int unsigned IDX_W = 7;
	localparam int unsigned CODE_W = 28;
	localparam logic [1:0] CH_NONE = 2'h0;
	localparam logic [1:0] CH_1 = 2'h1;
	localparam logic [1:0] CH_2 = 2'h2;
	typedef enum {ST_IDLE, ST_PROG, ST_DEL} rct_state_t;
	typedef struct packed {
		logic valid;
		logic [CODE_W-1:0] code;
	} rct_code_t;
	typedef struct packed {
		logic ch2;
		logic ch1;
	} rct_pair_t;
endpackage
`default_nettype wire

// [hw/rct_teach_in.sv]
// Teach-in button decoding, indicator drive and the transmitter code store.
// Assumes a decoded code with a one-cycle valid strobe from the radio side.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Lone hold: flash 5s, steady 15s, both 25s
// - Release after both lit erases all codes
// - One press channel 1, two channel 2
// - No code within 10s returns to normal
// - Code in programming stored, indicator off, done
// - At most 112 slots, repeat to add
// - Further presses cycle to none, cancelling
// - Hold 5s then release enters single deletion
// - Next code in deletion mode is removed
// - Every button combination is its own code
// - Channel chosen, hold 15s, release erases channel
module rct_teach_in #(
	parameter int unsigned TICK_CYCLES = rct_pkg::TICK_CYC,
	parameter int unsigned DEB_CYCLES = rct_pkg::DEB_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic learnBtn,
	input wire rct_pkg::rct_code_t codeIn,
	output rct_pkg::rct_pair_t leds,
	output rct_pkg::rct_pair_t cmd,
	output logic progDone,
	output logic delDone
);
	import rct_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES);
	localparam int DW = $clog2(DEB_CYCLES);

	// ****************************************
	// Button conditioning and time base
	// ****************************************
	logic sync1_reg, sync2_reg, btnStable_reg;
	logic sync1_next, sync2_next, btnStable_next;
	logic [TW-1:0] tickCnt_reg, tickCnt_next;
	logic [DW-1:0] debCnt_reg, debCnt_next;
	logic tick, accept, pressEv, relEv;

	// Two flops, then the level must stay put for the debounce window
	always_comb begin
		sync1_next = learnBtn;
		sync2_next = sync1_reg;
		tick = (tickCnt_reg == TW'(TICK_CYCLES - 1));
		tickCnt_next = tick ? '0 : tickCnt_reg + 1'b1;
		accept = 1'b0;
		btnStable_next = btnStable_reg;
		debCnt_next = '0;
		if (sync2_reg != btnStable_reg) begin
			if (debCnt_reg == DW'(DEB_CYCLES - 1)) begin
				accept = 1'b1;
				btnStable_next = sync2_reg;
			end else begin
				debCnt_next = debCnt_reg + 1'b1;
			end
		end
		pressEv = accept & sync2_reg;
		relEv = accept & ~sync2_reg;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			btnStable_reg <= 1'b0;
			tickCnt_reg <= '0;
			debCnt_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			btnStable_reg <= btnStable_next;
			tickCnt_reg <= tickCnt_next;
			debCnt_reg <= debCnt_next;
		end
	end

	// ****************************************
	// Code memory
	// ****************************************
	logic [NSLOT-1:0] slotValid_reg, slotChan_reg, hit;
	logic [CODE_W-1:0] slotCode_reg [NSLOT];
	logic [IDX_W-1:0] freeIdx;
	logic anyFree, doStore, doDelete, doEraseAll, doEraseChan;
	logic selCh2;
	rct_state_t state_reg, state_next;
	logic [1:0] chan_reg, chan_next;

	// Lowest free slot wins; a full store simply refuses new codes
	always_comb begin
		anyFree = 1'b0;
		freeIdx = '0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (!slotValid_reg[i]) begin
				anyFree = 1'b1;
				freeIdx = IDX_W'(i);
			end
		end
	end

	assign selCh2 = (chan_reg == CH_2);

	for (genvar i = 0; i < NSLOT; i++) begin : gSlot
		logic vNext, cNext;
		logic [CODE_W-1:0] codeNext;
		assign hit[i] = slotValid_reg[i] && slotCode_reg[i] == codeIn.code;
		// Erase beats delete beats store; only one can occur per cycle
		always_comb begin
			vNext = slotValid_reg[i];
			cNext = slotChan_reg[i];
			codeNext = slotCode_reg[i];
			if (doEraseAll) begin
				vNext = 1'b0;
			end else if (doEraseChan && slotChan_reg[i] == selCh2) begin
				vNext = 1'b0;
			end else if (doDelete && hit[i]) begin
				vNext = 1'b0;
			end else if (doStore && freeIdx == IDX_W'(i)) begin
				vNext = 1'b1;
				cNext = selCh2;
				codeNext = codeIn.code;
			end
		end
		always_ff @(posedge clk) begin
			if (!resetn) begin
				slotValid_reg[i] <= 1'b0;
				slotChan_reg[i] <= 1'b0;
				slotCode_reg[i] <= '0;
			end else begin
				slotValid_reg[i] <= vNext;
				slotChan_reg[i] <= cNext;
				slotCode_reg[i] <= codeNext;
			end
		end
	end

	// ****************************************
	// Teach-in sequencer and indicators
	// ****************************************
	logic [4:0] holdSec_reg, holdSec_next;
	logic [3:0] waitSec_reg, waitSec_next;
	logic blink_reg, blink_next;
	rct_pair_t leds_reg, leds_next, cmd_reg, cmd_next;
	logic progDone_reg, progDone_next, delDone_reg, delDone_next;
	logic shortHold, midHold, timeout;

	always_comb begin
		shortHold = holdSec_reg < HOLD_FLASH_S;
		midHold = !shortHold && holdSec_reg < HOLD_STEADY_S;
		timeout = (waitSec_reg == WAIT_CODE_S);
		state_next = state_reg;
		chan_next = chan_reg;
		cmd_next = '0;
		progDone_next = 1'b0;
		delDone_next = 1'b0;
		doStore = 1'b0;
		doDelete = 1'b0;
		doEraseAll = 1'b0;
		doEraseChan = 1'b0;
		// Hold time counts whole ticks from the debounced press
		holdSec_next = holdSec_reg;
		if (pressEv) begin
			holdSec_next = '0;
		end else if (btnStable_reg && tick && holdSec_reg < HOLD_ALL_S) begin
			holdSec_next = holdSec_reg + 5'h01;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (relEv) begin
					if (shortHold) begin
						state_next = ST_PROG;
						chan_next = CH_1;
					end else if (midHold) begin
						state_next = ST_DEL;
					end else if (holdSec_reg >= HOLD_ALL_S) begin
						doEraseAll = 1'b1;
					end
				end else if (codeIn.valid && !btnStable_reg) begin
					cmd_next.ch1 = |(hit & ~slotChan_reg);
					cmd_next.ch2 = |(hit & slotChan_reg);
				end
			end
			ST_PROG: begin
				if (relEv) begin
					state_next = ST_IDLE;
					chan_next = CH_NONE;
					if (shortHold && chan_reg == CH_1) begin
						state_next = ST_PROG;
						chan_next = CH_2;
					end else if (holdSec_reg >= HOLD_STEADY_S) begin
						doEraseChan = 1'b1;
					end
				end else if (codeIn.valid) begin
					// Known code is not stored twice; full store refuses
					doStore = anyFree && !(|hit);
					progDone_next = 1'b1;
					state_next = ST_IDLE;
					chan_next = CH_NONE;
				end else if (timeout) begin
					state_next = ST_IDLE;
					chan_next = CH_NONE;
				end
			end
			ST_DEL: begin
				if (codeIn.valid && !relEv) begin
					doDelete = 1'b1;
					delDone_next = 1'b1;
					state_next = ST_IDLE;
				end else if (relEv || timeout) begin
					state_next = ST_IDLE;
				end
			end
		endcase
		// Wait for a code only while the button is up
		waitSec_next = waitSec_reg;
		if (state_next != state_reg || btnStable_reg || state_reg == ST_IDLE) begin
			waitSec_next = '0;
		end else if (tick && !timeout) begin
			waitSec_next = waitSec_reg + 4'h1;
		end
		blink_next = tick ? ~blink_reg : blink_reg;
		// Indicator pattern from current state and hold time
		leds_next = '0;
		unique case (state_reg)
			ST_IDLE: begin
				if (btnStable_reg) begin
					if (holdSec_reg >= HOLD_ALL_S) begin
						leds_next = '{ch2: 1'b1, ch1: 1'b1};
					end else if (!shortHold) begin
						leds_next.ch1 = midHold ? blink_reg : 1'b1;
					end
				end
			end
			ST_PROG: begin
				leds_next.ch1 = (chan_reg == CH_1);
				leds_next.ch2 = selCh2;
				if (btnStable_reg && midHold && !blink_reg) begin
					leds_next = '0;
				end
			end
			ST_DEL: begin
				leds_next.ch1 = blink_reg;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			chan_reg <= CH_NONE;
			holdSec_reg <= '0;
			waitSec_reg <= '0;
			blink_reg <= 1'b0;
			leds_reg <= '0;
			cmd_reg <= '0;
			progDone_reg <= 1'b0;
			delDone_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			chan_reg <= chan_next;
			holdSec_reg <= holdSec_next;
			waitSec_reg <= waitSec_next;
			blink_reg <= blink_next;
			leds_reg <= leds_next;
			cmd_reg <= cmd_next;
			progDone_reg <= progDone_next;
			delDone_reg <= delDone_next;
		end
	end

	assign leds = leds_reg;
	assign cmd = cmd_reg;
	assign progDone = progDone_reg;
	assign delDone = delDone_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	all_leds_a: assert property (
		state_reg == ST_IDLE && btnStable_reg && holdSec_reg >= HOLD_ALL_S
		|=> leds_reg.ch1 && leds_reg.ch2)
		else $error("both indicators not lit after long hold");
	flash_led_a: assert property (
		state_reg == ST_IDLE && btnStable_reg && midHold
		|=> leds_reg.ch1 == $past(blink_reg) && !leds_reg.ch2)
		else $error("indicator not flashing in middle hold");
	erase_all_a: assert property (
		doEraseAll |=> slotValid_reg == '0)
		else $error("full erase left a slot");
	sel_ch1_a: assert property (
		state_reg == ST_IDLE && relEv && shortHold
		|=> state_reg == ST_PROG && chan_reg == CH_1 ##1 leds_reg.ch1)
		else $error("single press did not select channel 1");
	wait_end_a: assert property (
		state_reg == ST_PROG && timeout && !relEv && !codeIn.valid
		|=> state_reg == ST_IDLE)
		else $error("programming did not time out");
	store_a: assert property (
		state_reg == ST_PROG && codeIn.valid && !relEv && anyFree && !(|hit)
		|=> slotValid_reg[$past(freeIdx)] && progDone_reg
		&& slotCode_reg[$past(freeIdx)] == $past(codeIn.code))
		else $error("code not stored");
	full_a: assert property (
		state_reg == ST_PROG && codeIn.valid && !anyFree && !relEv
		|=> slotValid_reg == $past(slotValid_reg))
		else $error("store changed while full");
	cancel_a: assert property (
		state_reg == ST_PROG && chan_reg == CH_2 && relEv && shortHold
		|=> state_reg == ST_IDLE && chan_reg == CH_NONE)
		else $error("third press did not cancel");
	del_enter_a: assert property (
		state_reg == ST_IDLE && relEv && midHold |=> state_reg == ST_DEL)
		else $error("deletion mode not entered");
	del_code_a: assert property (
		state_reg == ST_DEL && codeIn.valid && !relEv
		|=> (slotValid_reg & $past(hit)) == '0 && delDone_reg)
		else $error("code not deleted");
	no_dup_a: assert property (
		state_reg == ST_PROG && codeIn.valid && !relEv && |hit
		|=> slotValid_reg == $past(slotValid_reg))
		else $error("known code stored again");
	chan_erase_a: assert property (
		state_reg == ST_PROG && relEv && holdSec_reg >= HOLD_STEADY_S
		|=> (slotValid_reg & ($past(selCh2) ? slotChan_reg : ~slotChan_reg))
		== '0)
		else $error("channel erase left a slot");
	cmd_src_a: assert property (
		cmd_reg != '0 |-> $past(codeIn.valid) && $past(state_reg) == ST_IDLE)
		else $error("command pulse without matching code");
	debounce_a: assert property (
		btnStable_reg != $past(btnStable_reg)
		|-> $past(debCnt_reg) == DW'(DEB_CYCLES - 1))
		else $error("button accepted before debounce");
	store_c: cover property (doStore);
	erase_c: cover property (doEraseAll);
	del_c: cover property (doDelete);
	cmd_c: cover property (cmd_reg.ch2);
endmodule
`default_nettype wire

// [tb/rct_radio_model.sv]
// Behavioural radio front end that hands decoded transmitter codes over.
// Assumes the consumer samples on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rct_radio_model (
	input wire logic clk,
	output rct_pkg::rct_code_t codeOut
);
	import rct_pkg::*;
	// ****************************************
	// Code strobe
	// ****************************************
	// Idle bus shows no usable code, so a stale value cannot pass as valid
	initial begin
		codeOut = {1'b0, {CODE_W{1'b1}}};
	end
	// One-cycle strobe per button code; every combination is its own code
	task automatic send(input logic [CODE_W-1:0] c);
		@(negedge clk);
		codeOut.valid = 1'b1;
		codeOut.code = c;
		@(negedge clk);
		codeOut.valid = 1'b0;
		codeOut.code = ~c; // Released data shows inverse, not last code
	endtask
endmodule
`default_nettype wire

// [tb/rct_teach_in_tb_top.sv]
// Self-checking bench of the teach-in controller: table rows first, then
// full erase, slot limit. Assumes shortened tick and debounce counts.
`timescale 1ns/100ps
`default_nettype none
module rct_teach_in_tb_top;
	import rct_pkg::*;
	// ****************************************
	// Setup
	// ****************************************
	localparam int TCK = 20;
	localparam int LIMIT = 20000;
	typedef struct {
		int op;
		int arg;
		logic [1:0] led;
		logic [3:0] pul;
	} rct_row_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic learnBtn = 1'b0;
	rct_code_t codeIn;
	rct_pair_t leds;
	rct_pair_t cmd;
	logic progDone;
	logic delDone;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	// Op 0 press and look at leds, 1 send code, 2 wait ticks, 3 press only
	rct_row_t rows [28] = '{
		'{1, 32'ha1, 2'h0, 4'h0},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{1, 32'ha1, 2'h0, 4'h2},
		'{1, 32'ha1, 2'h0, 4'h4},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{0, 2 * TCK, 2'h2, 4'h0},
		'{1, 32'hb2, 2'h0, 4'h2},
		'{1, 32'hb2, 2'h0, 4'h8},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{0, 2 * TCK, 2'h2, 4'h0},
		'{0, 2 * TCK, 2'h0, 4'h0},
		'{1, 32'hc3, 2'h0, 4'h0},
		'{0, 2, 2'h0, 4'h0},
		'{0, 18 * TCK, 2'h0, 4'h0},
		'{3, 8 * TCK, 2'h0, 4'h0},
		'{1, 32'ha1, 2'h0, 4'h1},
		'{1, 32'ha1, 2'h0, 4'h0},
		'{1, 32'hb2, 2'h0, 4'h8},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{2, 12, 2'h0, 4'h0},
		'{1, 32'ha1, 2'h0, 4'h0},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{1, 32'ha1, 2'h0, 4'h2},
		'{0, 2 * TCK, 2'h1, 4'h0},
		'{0, 2 * TCK, 2'h2, 4'h0},
		'{0, 18 * TCK, 2'h0, 4'h0},
		'{1, 32'hb2, 2'h0, 4'h0},
		'{1, 32'ha1, 2'h0, 4'h4}
	};
	// Free-running clock
	always #5 clk = ~clk;
	rct_teach_in #(.TICK_CYCLES(TCK), .DEB_CYCLES(4)) DUT (
		.clk(clk),
		.resetn(resetn),
		.learnBtn(learnBtn),
		.codeIn(codeIn),
		.leds(leds),
		.cmd(cmd),
		.progDone(progDone),
		.delDone(delDone)
	);
	rct_radio_model R (
		.clk(clk),
		.codeOut(codeIn)
	);
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [3:0] pulses();
		return {cmd, progDone, delDone};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hold for n cycles; the wait after covers debounce plus led lag
	task automatic press(int n);
		@(negedge clk);
		learnBtn = 1'b1;
		repeat (n) @(negedge clk);
		learnBtn = 1'b0;
		repeat (14) @(negedge clk);
	endtask
	// Pulses are one cycle wide, so they are caught in that very cycle
	task automatic sendCode(logic [CODE_W-1:0] c, output logic [3:0] p);
		R.send(c);
		p = pulses();
		@(negedge clk);
	endtask
	// Hang guard, reckoned well above the whole sequence
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			summarize();
		end
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		logic [3:0] p;
		@(negedge clk);
		check("reset", {leds, pulses()} == 6'h0 ? 4'h0 : 4'h1, 4'h0);
		@(negedge clk);
		resetn = 1'b1;
		foreach (rows[i]) begin
			case (rows[i].op)
				1: begin
					sendCode(CODE_W'(rows[i].arg), p);
					check("pulses", p, rows[i].pul);
				end
				2: repeat (rows[i].arg * TCK) @(negedge clk);
				default: press(rows[i].arg);
			endcase
			if (rows[i].op != 1) check("idle", pulses(), 4'h0);
			if (rows[i].op != 3) check("leds", {2'h0, leds}, {2'h0, rows[i].led});
		end
		// Long hold with no channel checks the off, steady and both-lit indicator stages
		@(negedge clk);
		learnBtn = 1'b1;
		repeat (3 * TCK) @(negedge clk);
		check("leds", {2'h0, leds}, 4'h0);
		repeat (14 * TCK) @(negedge clk);
		check("leds", {2'h0, leds}, 4'h1);
		repeat (10 * TCK) @(negedge clk);
		check("leds", {2'h0, leds}, 4'h3);
		learnBtn = 1'b0;
		repeat (14) @(negedge clk);
		check("leds", {2'h0, leds}, 4'h0);
		sendCode(28'h00000a1, p);
		check("pulses", p, 4'h0);
		// Fill every slot, then one more is refused but still completes
		for (int i = 0; i < NSLOT; i++) begin
			press(2 * TCK);
			sendCode(CODE_W'(32'h100 + i), p);
			check("pulses", p, 4'h2);
		end
		press(2 * TCK);
		sendCode(28'h0000300, p);
		check("pulses", p, 4'h2);
		sendCode(28'h0000300, p);
		check("pulses", p, 4'h0);
		sendCode(28'h000016f, p);
		check("pulses", p, 4'h4);
		// Mid-run reset clears the store; a known code is not kept twice
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		check("reset", {2'h0, leds}, 4'h0);
		check("pulses", pulses(), 4'h0);
		resetn = 1'b1;
		sendCode(28'h000016f, p);
		check("pulses", p, 4'h0);
		press(2 * TCK);
		sendCode(28'h000005a, p);
		check("pulses", p, 4'h2);
		press(2 * TCK);
		sendCode(28'h000005a, p);
		check("pulses", p, 4'h2);
		sendCode(28'h000005a, p);
		check("pulses", p, 4'h4);
		summarize();
	end
endmodule
`default_nettype wire
